// ---- logic/seewa_cfg.svh ----
// Purpose: constants for the serial EEPROM erase and write-all command block
// Assumes: x16 organisation, 64 words, 100 MHz core clock
// Notes:   program cycle time is a parameter default of the top module
`ifndef SEEWA_CFG_SVH
`define SEEWA_CFG_SVH

`define SEEWA_WORD_W        16
`define SEEWA_ADDR_W        6
`define SEEWA_DEPTH         64
`define SEEWA_OP_W          2
`define SEEWA_OP_ERASE      2'h3
`define SEEWA_OP_WRITE      2'h1
`define SEEWA_OP_READ       2'h2
`define SEEWA_OP_SPECIAL    2'h0
`define SEEWA_SUB_ENABLE    2'h3
`define SEEWA_SUB_DISABLE   2'h0
`define SEEWA_SUB_CLEARALL  2'h2
`define SEEWA_SUB_WRITEALL  2'h1
`define SEEWA_CLK_MHZ       100
`define SEEWA_PROG_TIME_US  5000
`define SEEWA_PROG_CYCLES   (`SEEWA_PROG_TIME_US * `SEEWA_CLK_MHZ)
`define SEEWA_HDR_BITS      9
`define SEEWA_ERASED_WORD   16'hFFFF

`endif

// ---- logic/seewa_pkg.sv ----
// Purpose: types for the serial EEPROM erase and write-all command block
// Assumes: constants come from seewa_cfg.svh
// Notes:   none
`include "seewa_cfg.svh"

package seewa_pkg;

    typedef enum logic [1:0] {
        SEEWA_IDLE,
        SEEWA_SHIFT,
        SEEWA_WAIT
    } seewa_state_t;

    typedef enum logic [1:0] {
        SEEWA_JOB_NONE,
        SEEWA_JOB_ERASE,
        SEEWA_JOB_CLEARALL,
        SEEWA_JOB_WRITEALL
    } seewa_job_t;

    typedef struct packed {
        seewa_job_t                 job;
        logic [`SEEWA_ADDR_W-1:0]   addr;
        logic [`SEEWA_WORD_W-1:0]   data;
    } seewa_cmd_t;

endpackage : seewa_pkg

// ---- logic/seewa_core.sv ----
// Purpose: serial EEPROM erase, erase-all and write-all command handling
// Assumes: serial pins are asynchronous and sampled by clk
// Notes:   memory array is held in flip-flops for model purposes
// Operation
// - Select fall after erase starts clear
// - Internal cycle runs without serial clock
// - Host polls busy by raising select
// - Erased word reads all ones
// - Select fall after clear-all clears array
// - Clear-all leaves every bit one
// - Select fall after write-all stores everywhere
// - Write-all needs no prior erase
// - Start bit, opcode, address, data format
// - Output low busy, high ready
// - Programming needs prior write enable
`timescale 1ns/1ns
`include "seewa_cfg.svh"

module seewa_core
    import seewa_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `SEEWA_PROG_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Serial pins
    input  wire logic                     chipSelect,
    input  wire logic                     serial_clock,
    input  wire logic                     serial_data_in,
    output logic                          serialDataOut,
    output logic                          serialDataOutEn,
    // Array inspection and busy status
    input  wire logic [`SEEWA_ADDR_W-1:0] peekAddr,
    output logic [`SEEWA_WORD_W-1:0]      peekData,
    output logic                          busy
);

    logic [2:0]                 csSync;
    logic [2:0]                 skSync;
    logic [1:0]                 diSync;
    logic                       csRise;
    logic                       csFall;
    logic                       skRise;
    seewa_state_t               state_reg;
    logic [4:0]                 bitCnt_reg;
    logic [`SEEWA_HDR_BITS-1:0] hdr_reg;
    logic [`SEEWA_WORD_W-1:0]   data_reg;
    logic                       writeEn_reg;
    seewa_cmd_t                 pend_reg;
    seewa_cmd_t                 run_reg;
    logic [31:0]                timer_reg;
    logic                       busy_reg;
    logic                       doActive_reg;
    logic [`SEEWA_WORD_W-1:0]   mem [`SEEWA_DEPTH];
    logic [`SEEWA_WORD_W-1:0]   peekData_reg;
    logic [`SEEWA_OP_W-1:0]     opcode;
    logic [`SEEWA_OP_W-1:0]     subOp;
    logic                       progDone;

    // Second stage onward only feeds logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csSync <= 3'h0;
            skSync <= 3'h0;
            diSync <= 2'h0;
        end else begin
            csSync <= {csSync[1:0], chipSelect};
            skSync <= {skSync[1:0], serial_clock};
            diSync <= {diSync[0], serial_data_in};
        end
    end

    assign csRise = csSync[1] & ~csSync[2];
    assign csFall = ~csSync[1] & csSync[2];
    assign skRise = skSync[1] & ~skSync[2];
    assign opcode = hdr_reg[7:6];
    assign subOp  = hdr_reg[5:4];
    assign progDone = busy_reg && (timer_reg == 32'h0);

    // Instruction shifter: start bit, 2-bit opcode, 6-bit address, data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= SEEWA_IDLE;
            bitCnt_reg <= 5'h0;
            hdr_reg    <= '0;
            data_reg   <= '0;
        end else if (!csSync[1]) begin
            state_reg  <= SEEWA_IDLE;
            bitCnt_reg <= 5'h0;
        end else if (skRise) begin
            case (state_reg)
                SEEWA_IDLE: begin
                    // Leading zeros are ignored until the start bit
                    if (diSync[1] && !busy_reg) begin
                        hdr_reg    <= {{(`SEEWA_HDR_BITS-1){1'b0}}, 1'b1};
                        bitCnt_reg <= 5'h1;
                        state_reg  <= SEEWA_SHIFT;
                    end
                end
                SEEWA_SHIFT: begin
                    if (bitCnt_reg < 5'(`SEEWA_HDR_BITS)) begin
                        hdr_reg <= {hdr_reg[`SEEWA_HDR_BITS-2:0], diSync[1]};
                    end else begin
                        data_reg <= {data_reg[`SEEWA_WORD_W-2:0], diSync[1]};
                    end
                    bitCnt_reg <= bitCnt_reg + 5'h1;
                    if (bitCnt_reg == 5'(`SEEWA_HDR_BITS + `SEEWA_WORD_W - 1)) begin
                        state_reg <= SEEWA_WAIT;
                    end
                end
                SEEWA_WAIT: state_reg <= SEEWA_WAIT;
                default:    state_reg <= SEEWA_IDLE;
            endcase
        end
    end

    // Decode the shifted frame into a pending job
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            writeEn_reg <= 1'b0;
            pend_reg    <= '0;
        end else if (csSync[1]) begin
            pend_reg.job <= SEEWA_JOB_NONE;
            if (bitCnt_reg >= 5'(`SEEWA_HDR_BITS) && hdr_reg[8]) begin
                pend_reg.addr <= hdr_reg[`SEEWA_ADDR_W-1:0];
                pend_reg.data <= data_reg;
                if (opcode == `SEEWA_OP_ERASE && writeEn_reg) begin
                    pend_reg.job <= SEEWA_JOB_ERASE;
                end else if (opcode == `SEEWA_OP_SPECIAL) begin
                    if (subOp == `SEEWA_SUB_CLEARALL && writeEn_reg) begin
                        pend_reg.job <= SEEWA_JOB_CLEARALL;
                    end else if (subOp == `SEEWA_SUB_WRITEALL && writeEn_reg
                                 && state_reg == SEEWA_WAIT) begin
                        pend_reg.job <= SEEWA_JOB_WRITEALL;
                    end
                end
            end
            if (bitCnt_reg == 5'(`SEEWA_HDR_BITS) && hdr_reg[8]
                && opcode == `SEEWA_OP_SPECIAL) begin
                if (subOp == `SEEWA_SUB_ENABLE) begin
                    writeEn_reg <= 1'b1;
                end else if (subOp == `SEEWA_SUB_DISABLE) begin
                    writeEn_reg <= 1'b0;
                end
            end
        end
    end

    // Self-timed cycle on the core clock; serial clock is not needed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg  <= 1'b0;
            timer_reg <= 32'h0;
            run_reg   <= '0;
        end else if (csFall && !busy_reg && pend_reg.job != SEEWA_JOB_NONE) begin
            busy_reg  <= 1'b1;
            timer_reg <= PROG_CYCLES - 1;
            run_reg   <= pend_reg;
        end else if (busy_reg) begin
            if (timer_reg != 32'h0) begin
                timer_reg <= timer_reg - 32'h1;
            end else begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Array update at end of cycle; writes overwrite old data directly
    // One process per word, so each word has a single driver
    // Array is not reset: contents stay unknown until first written
    for (genvar g = 0; g < `SEEWA_DEPTH; g++) begin : g_word
        localparam int unsigned WordIdx = g;
        always_ff @(posedge clk) begin
            if (progDone) begin
                case (run_reg.job)
                    SEEWA_JOB_ERASE: begin
                        if (32'(run_reg.addr) == WordIdx) begin
                            mem[g] <= `SEEWA_ERASED_WORD;
                        end
                    end
                    SEEWA_JOB_CLEARALL: mem[g] <= `SEEWA_ERASED_WORD;
                    SEEWA_JOB_WRITEALL: mem[g] <= run_reg.data;
                    default:            mem[g] <= mem[g];
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peekData_reg <= '0;
        end else begin
            peekData_reg <= mem[peekAddr];
        end
    end

    // Status output: enabled on select rise during or after a cycle, dropped by a
    // dummy one clocked in once ready, and always on select low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doActive_reg <= 1'b0;
        end else if (!csSync[1]) begin
            doActive_reg <= 1'b0;
        end else if (csRise && (busy_reg || run_reg.job != SEEWA_JOB_NONE)) begin
            doActive_reg <= 1'b1;
        end else if (skRise && diSync[1] && !busy_reg) begin
            doActive_reg <= 1'b0;
        end
    end

    assign serialDataOutEn = doActive_reg && csSync[1];
    assign serialDataOut   = !busy_reg;
    assign peekData        = peekData_reg;
    assign busy            = busy_reg;

endmodule : seewa_core

// ---- verification/seewa_core_assertions.sv ----
// Purpose: port checks for the erase and write-all command block
// Assumes: host keeps select high at least 4 clk and low at least 6 clk
// Notes:   busy length is counted in helper logic
`timescale 1ns/1ns
module seewa_core_assertions #(
    parameter int unsigned PROG_CYCLES = 50
) (
    // Clock, reset and pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipSelect,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    input wire logic busy
);
    int unsigned busyCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busyCnt <= 0;
        else busyCnt <= busy ? busyCnt + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    float_low_a: assert property (!chipSelect [*4] |-> !serialDataOutEn)
        else $error("output driven while deselected");
    poll_busy_a: assert property (serialDataOutEn && busy |-> !serialDataOut)
        else $error("busy not shown low");
    poll_ready_a: assert property (serialDataOutEn && !busy |-> serialDataOut)
        else $error("ready not shown high");
    busy_start_a: assert property ($rose(busy) |-> !$past(chipSelect) && !$past(chipSelect, 2))
        else $error("cycle began while selected");
    busy_hold_a: assert property ($rose(busy) |=> busy [*8])
        else $error("cycle cut short");
    busy_len_a: assert property ($fell(busy) |-> busyCnt == PROG_CYCLES)
        else $error("cycle length wrong");
    poll_grant_a: assert property ($rose(chipSelect) && busy |-> ##[2:4] serialDataOutEn)
        else $error("poll not answered");
    en_select_a: assert property ($rose(serialDataOutEn) |-> chipSelect)
        else $error("output enabled without select");
endmodule : seewa_core_assertions

// ---- verification/seewa_host.sv ----
// Purpose: host controller driving the serial pins
// Assumes: link clock period 125 ns, phase unrelated to clk
// Notes:   link clock stands low between frames
`timescale 1ns/1ns
module seewa_host (
    // Pins
    input  wire logic clk,
    output logic      chipSelect,
    output logic      serialClock,
    output logic      serialData,
    input  wire logic dataOut,
    input  wire logic dataOutEn
);
    initial begin
        chipSelect = 1'b0;
        serialClock = 1'b0;
        serialData = 1'b1;
    end
    task automatic frame(input logic [24:0] bits, input int n);
        @(posedge clk) chipSelect <= 1'b1;
        #2;
        for (int i = n - 1; i >= 0; i--) begin
            serialData = bits[i];
            #62 serialClock = 1'b1;
            #63 serialClock = 1'b0;
        end
        @(posedge clk) chipSelect <= 1'b0;
        serialData <= ~bits[0];
        repeat (8) @(posedge clk);
    endtask : frame
    task automatic poll(output logic sawBusy, output int waited);
        @(posedge clk) chipSelect <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk) sawBusy = dataOutEn && !dataOut;
        for (waited = 0; waited < 500 && !(dataOutEn && dataOut); waited++) @(negedge clk);
        @(posedge clk) chipSelect <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : poll
endmodule : seewa_host

// ---- verification/seewa_core_tb.sv ----
// Purpose: self-checking bench for the erase and write-all command block
// Assumes: shortened program cycle of 50 clk
// Notes:   array contents seen through the peek port
`timescale 1ns/1ns
`include "seewa_cfg.svh"
module seewa_core_tb;
    localparam int unsigned PCYC = 50;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic [`SEEWA_ADDR_W-1:0] peekAddr = '0;
    logic [`SEEWA_WORD_W-1:0] peekData;
    logic                     cs, sk, sdi, sdo, sdoEn, busy;
    int                       errorCnt = 0;
    int                       checksDone = 0;
    always #5 clk = ~clk;
    seewa_host host (.clk(clk), .chipSelect(cs), .serialClock(sk), .serialData(sdi),
        .dataOut(sdo), .dataOutEn(sdoEn));
    seewa_core #(.PROG_CYCLES(PCYC)) uut (.clk(clk), .rst_n(rst_n), .chipSelect(cs),
        .serial_clock(sk), .serial_data_in(sdi), .serialDataOut(sdo),
        .serialDataOutEn(sdoEn), .peekAddr(peekAddr), .peekData(peekData), .busy(busy));
    task automatic chk1(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t flag %b exp %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t word %h exp %h", $time, got, exp);
        end
    endtask : chkW
    task automatic printVerdict();
        $display("errors %0d checks %0d", errorCnt, checksDone);
        if (errorCnt == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : printVerdict
    // Busy frames are polled; refused ones must leave busy low
    task automatic prog(input logic [24:0] bits, input int n, input logic expBusy);
        logic sawBusy;
        int   waited;
        host.frame(bits, n);
        if (expBusy) begin
            host.poll(sawBusy, waited);
            chk1(sawBusy, 1'b1);
            chk1(waited < 500, 1'b1);
            if (waited >= 500) printVerdict();
        end else begin
            repeat (20) @(posedge clk);
            @(negedge clk) chk1(busy, 1'b0);
        end
    endtask : prog
    task automatic checkArray(input logic [15:0] fill, input int hole, input logic [15:0] hv);
        for (int i = 0; i < `SEEWA_DEPTH; i++) begin
            @(posedge clk) peekAddr <= i[5:0];
            @(posedge clk);
            @(negedge clk) chkW(peekData, i == hole ? hv : fill);
        end
    endtask : checkArray
    task automatic tWriteAll();
        prog(25'h1100000, 25, 1'b1);
        prog({9'h110, 16'h5A3C}, 25, 1'b1);
        checkArray(16'h5A3C, -1, 16'h0000);
    endtask : tWriteAll
    task automatic tErase();
        prog({3'h7, 6'h05}, 9, 1'b1);
        checkArray(16'h5A3C, 5, 16'hFFFF);
        prog(25'h0000120, 9, 1'b1);
        checkArray(16'hFFFF, -1, 16'h0000);
    endtask : tErase
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        prog(25'h0000120, 9, 1'b0);
        prog(25'h0000130, 9, 1'b0);
        tWriteAll();
        tErase();
        prog(25'h0000100, 9, 1'b0);
        prog({3'h7, 6'h07}, 9, 1'b0);
        printVerdict();
    end
endmodule : seewa_core_tb
bind seewa_core seewa_core_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk (.clk(clk),
    .rst_n(rst_n), .chipSelect(chipSelect), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .busy(busy));
